// >>> logic/msh_pkg.sv
// Shared constants and types of the multiplier based shifter pair.
package msh_pkg;

    localparam int A_W    = 25;
    localparam int B_W    = 18;
    localparam int M_W    = 43;
    localparam int P_W    = 48;
    localparam int XYZ_W  = 7;
    localparam int ALU_W  = 4;
    localparam int CSEL_W = 3;
    localparam int K_W    = 5;
    localparam int NSLICE = 2;
    localparam int B_MSB  = 17;
    localparam int ROT_W  = 18;

    ////////////////////////////////////////////////////////////////////////
    localparam logic [K_W-1:0] K_MAX      = 5'h11;
    localparam int             CASC_SHIFT = 18;
    localparam int             OUT_LAT    = 6;
    localparam int             MODE_LAT   = 4;

    ////////////////////////////////////////////////////////////////////////
    localparam logic [ALU_W-1:0] ALU_ADD    = 4'h0;
    localparam logic [ALU_W-1:0] ALU_NZADD  = 4'h1;
    localparam logic [ALU_W-1:0] ALU_NOTADD = 4'h2;
    localparam logic [ALU_W-1:0] ALU_SUB    = 4'h3;
    localparam logic [ALU_W-1:0] ALU_XOR    = 4'h4;
    localparam logic [ALU_W-1:0] ALU_AND    = 4'hC;
    localparam logic [ALU_W-1:0] ALU_OR     = 4'hE;

    localparam logic [1:0] XM_ZERO = 2'h0;
    localparam logic [1:0] XM_MULT = 2'h1;
    localparam logic [1:0] XM_P    = 2'h2;
    localparam logic [1:0] XM_AB   = 2'h3;
    localparam logic [1:0] YM_ZERO = 2'h0;
    localparam logic [1:0] YM_MULT = 2'h1;
    localparam logic [1:0] YM_ONES = 2'h2;
    localparam logic [1:0] YM_C    = 2'h3;
    localparam logic [2:0] ZM_ZERO = 3'h0;
    localparam logic [2:0] ZM_CASC = 3'h1;
    localparam logic [2:0] ZM_P    = 3'h2;
    localparam logic [2:0] ZM_C    = 3'h3;
    localparam logic [2:0] ZM_CSH  = 3'h5;
    localparam logic [2:0] ZM_PSH  = 3'h6;

    localparam logic [CSEL_W-1:0] CS_FABRIC = 3'h0;
    localparam logic [CSEL_W-1:0] CS_PSIGN  = 3'h1;

    localparam logic [XYZ_W-1:0] XYZ_MULT      = 7'h05;
    localparam logic [XYZ_W-1:0] XYZ_MULT_CASC = 7'h55;

    typedef enum logic [1:0]
    {
        SH_ARITH   = 2'h0,
        SH_LOGIC   = 2'h1,
        SH_REVERSE = 2'h3,
        SH_ROTATE  = 2'h2
    } msh_mode_type;

endpackage

// >>> logic/msh_link_if.sv
// Link between the fabric control logic and the two shifter slices.
`timescale 1ns/1ps
interface msh_link_if;
    logic                                    ce;
    logic                                    resultClear;
    logic [msh_pkg::A_W-1:0]                 aOperand;
    logic [msh_pkg::B_W-1:0]                 bOperand;
    logic [msh_pkg::P_W-1:0]                 cOperand;
    logic [msh_pkg::A_W-1:0]                 aCascadeIn;
    logic [msh_pkg::B_W-1:0]                 bCascadeIn;
    logic [1:0]                              aFromCascade;
    logic [1:0]                              bFromCascade;
    logic [1:0][msh_pkg::XYZ_W-1:0]          xyzMuxSelect;
    logic [1:0][msh_pkg::ALU_W-1:0]          aluFunctionSelect;
    logic [1:0][msh_pkg::CSEL_W-1:0]         carrySourceSelect;
    logic [1:0]                              carryIn;
    logic [1:0][msh_pkg::P_W-1:0]            result;
    logic [msh_pkg::B_W-1:0]                 bCascadeOut;
    logic [msh_pkg::P_W-1:0]                 resultCascadeOut;

    modport slice
    (
        input  ce, resultClear, aOperand, bOperand, cOperand,
        input  aCascadeIn, bCascadeIn, aFromCascade, bFromCascade,
        input  xyzMuxSelect, aluFunctionSelect, carrySourceSelect, carryIn,
        output result, bCascadeOut, resultCascadeOut
    );

    modport fabric
    (
        output ce, resultClear, aOperand, bOperand, cOperand,
        output aCascadeIn, bCascadeIn, aFromCascade, bFromCascade,
        output xyzMuxSelect, aluFunctionSelect, carrySourceSelect, carryIn,
        input  result, bCascadeOut, resultCascadeOut
    );
endinterface

// >>> logic/msh_fabric_ctl.sv
// Fabric end: builds the shift code and shapes the operand and outputs per mode.
`timescale 1ns/1ps
module msh_fabric_ctl
(
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      inValid,
    input  wire logic [msh_pkg::A_W-1:0]   inData,
    input  wire logic [msh_pkg::K_W-1:0]   inShift,
    input  wire msh_pkg::msh_mode_type     inMode,
    output logic                           outValid,
    output logic [msh_pkg::A_W-1:0]        outLeft,
    output logic [msh_pkg::A_W-1:0]        outRight,
    output logic [msh_pkg::ROT_W-1:0]      outRotate,
    msh_link_if.fabric                     lnk
);
    import msh_pkg::*;

    typedef struct packed
    {
        logic                              ceDrv;
        logic                              clearDrv;
        logic [A_W-1:0]                    aDrv;
        logic [B_W-1:0]                    bDrv;
        logic [2:0]                        sub;
        logic [OUT_LAT-1:0]                vld;
        logic [MODE_LAT-1:0][1:0]          mode;
        logic [A_W-1:0]                    leftHold;
        logic [A_W-1:0]                    rightHold;
        logic [A_W-1:0]                    left;
        logic [A_W-1:0]                    right;
        logic [ROT_W-1:0]                  rot;
    } msh_fab_state_type;

    msh_fab_state_type s_q;
    msh_fab_state_type s_d;
    logic [K_W-1:0]    kSat;

    function automatic logic [A_W-1:0] bit_rev(logic [A_W-1:0] v);
        logic [A_W-1:0] r;
        r = '0;
        for (int i = 0; i < A_W; i++)
        begin
            r[i] = v[A_W-1-i];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        s_d          = s_q;
        s_d.ceDrv    = 1'b1;
        s_d.clearDrv = 1'b0;
        kSat = (inShift > K_MAX) ? K_MAX : inShift;
        s_d.bDrv = inValid ? (B_W'(1) << kSat) : '0;
        unique case (inMode)
            SH_ARITH:   s_d.aDrv = {{(A_W-B_W){inData[B_MSB]}},
                                    inData[B_W-1:0]};
            SH_LOGIC:   s_d.aDrv = {{(A_W-B_W){1'b0}},
                                    inData[B_W-1:0]};
            SH_REVERSE: s_d.aDrv = bit_rev(inData);
            SH_ROTATE:  s_d.aDrv = {{(A_W-B_W){1'b0}},
                                    inData[B_W-1:0]};
        endcase
        // The subtract flag trails the code so it meets each ALU stage.
        s_d.sub = {s_q.sub[1:0], s_d.bDrv[B_MSB]};
        s_d.vld  = {s_q.vld[OUT_LAT-2:0], inValid};
        s_d.mode = {s_q.mode[MODE_LAT-2:0], inMode};
        s_d.leftHold = lnk.result[0][A_W-1:0];
        s_d.rightHold = (s_q.mode[MODE_LAT-1] == SH_REVERSE)
                      ? bit_rev(lnk.result[0][A_W-1:0])
                      : lnk.result[0][CASC_SHIFT+A_W-1:CASC_SHIFT];
        s_d.left  = s_q.leftHold;
        s_d.right = s_q.rightHold;
        s_d.rot   = lnk.result[1][ROT_W-1:0];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s_q          <= '0;
            s_q.clearDrv <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign lnk.ce                   = s_q.ceDrv;
    assign lnk.resultClear          = s_q.clearDrv;
    assign lnk.aOperand             = s_q.aDrv;
    assign lnk.bOperand             = s_q.bDrv;
    assign lnk.cOperand             = '0;
    assign lnk.aCascadeIn           = '0;
    assign lnk.bCascadeIn           = '0;
    assign lnk.aFromCascade         = 2'h2;
    assign lnk.bFromCascade         = 2'h2;
    assign lnk.xyzMuxSelect[0]      = XYZ_MULT;
    assign lnk.xyzMuxSelect[1]      = XYZ_MULT_CASC;
    assign lnk.aluFunctionSelect[0] = s_q.sub[1] ? ALU_SUB : ALU_ADD;
    assign lnk.aluFunctionSelect[1] = s_q.sub[2] ? ALU_SUB : ALU_ADD;
    assign lnk.carrySourceSelect[0] = CS_FABRIC;
    assign lnk.carrySourceSelect[1] = CS_FABRIC;
    assign lnk.carryIn              = 2'h0;
    assign outValid                 = s_q.vld[OUT_LAT-1];
    assign outLeft                  = s_q.left;
    assign outRight                 = s_q.right;
    assign outRotate                = s_q.rot;

endmodule

// >>> logic/msh_slice_pair.sv
// Device end: two cascaded pipelined multiply and add/logic slices.
// Contract
// - Clock enable high before edge to sample.
// - C operand sampled one edge after A/B; here C is registered on the same edge as A/B.
// - Result appears after third edge.
// - Reset clears result register synchronously.
// - A/B source: fabric or cascade, per operand.
// - Fields pick muxes, ALU function, carry.
// - Control fields may change every cycle.
// - Product by two-power-K shifts left K.
// - Operand up to 25 bits, K at most 17.
// - Product low 18 bits hold left shift.
// - Bits 35..18 hold arithmetic right shift.
// - 25-bit: left 24..0, right 42..18.
// - Zero padding gives logical right shift.
// - Bit reversal gives unsigned right shift.
// - Subtract when shift code MSB set.
// - Function select delayed by two registers.
// - Barrel rotates; MSB bits wrap to LSB.
// - Fabric converts K to one-hot code.
// - First slice cascades B and result onward.
// - Function low bits follow registered code MSB.
// - Second slice adds product to shifted cascade.
`timescale 1ns/1ps
module msh_slice_pair
(
    input  wire logic clk,
    input  wire logic rst_n,
    msh_link_if.slice lnk
);
    import msh_pkg::*;

    typedef struct packed
    {
        logic [NSLICE-1:0][A_W-1:0]    a;
        logic [NSLICE-1:0][B_W-1:0]    b;
        logic [NSLICE-1:0][M_W-1:0]    m;
        logic [NSLICE-1:0][P_W-1:0]    c;
        logic [NSLICE-1:0][XYZ_W-1:0]  xyz;
        logic [NSLICE-1:0][ALU_W-1:0]  alu;
        logic [NSLICE-1:0][CSEL_W-1:0] csel;
        logic [NSLICE-1:0]             cin;
        logic [NSLICE-1:0][P_W-1:0]    p;
    } msh_slice_state_type;

    msh_slice_state_type s_q;
    msh_slice_state_type s_d;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [P_W-1:0] alu_op
    (
        logic [P_W-1:0]   x,
        logic [P_W-1:0]   y,
        logic [P_W-1:0]   z,
        logic             ci,
        logic [ALU_W-1:0] f
    );
        logic [P_W-1:0] xy;
        logic [P_W-1:0] r;
        xy = x + y + {{(P_W-1){1'b0}}, ci};
        // A code with no listed meaning falls back to the plain sum.
        case (f)
            ALU_ADD:    r = z + xy;
            ALU_NZADD:  r = ~z + xy;
            ALU_NOTADD: r = ~(z + xy);
            ALU_SUB:    r = z - xy;
            ALU_XOR:    r = x ^ z;
            ALU_AND:    r = x & z;
            ALU_OR:     r = x | z;
            default:    r = z + xy;
        endcase
        return r;
    endfunction

    function automatic logic [P_W-1:0] prod_ext(logic [M_W-1:0] m);
        return {{(P_W-M_W){m[M_W-1]}}, m};
    endfunction

    function automatic logic [P_W-1:0] casc_shift(logic [P_W-1:0] v);
        return P_W'($signed(v) >>> CASC_SHIFT);
    endfunction

    // Both operands widen to the product width first, because a plain
    // signed multiply is only as wide as its wider operand.
    function automatic logic [M_W-1:0] mul_ext
    (
        logic [A_W-1:0] a,
        logic [B_W-1:0] b
    );
        logic signed [M_W-1:0] aw;
        logic signed [M_W-1:0] bw;
        aw = M_W'($signed(a));
        bw = M_W'($signed(b));
        return aw * bw;
    endfunction

    function automatic logic carry_pick
    (
        logic [CSEL_W-1:0] sel,
        logic              pSign,
        logic              fabricCarry
    );
        return (sel == CS_PSIGN) ? ~pSign : fabricCarry;
    endfunction

    function automatic logic [P_W-1:0] z_pick
    (
        logic [2:0]     code,
        logic [P_W-1:0] cascV,
        logic [P_W-1:0] pV,
        logic [P_W-1:0] cV
    );
        logic [P_W-1:0] r;
        r = '0;
        case (code)
            ZM_ZERO: r = '0;
            ZM_CASC: r = cascV;
            ZM_P:    r = pV;
            ZM_C:    r = cV;
            ZM_CSH:  r = casc_shift(cascV);
            ZM_PSH:  r = casc_shift(pV);
            default: r = '0;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [P_W-1:0]  xv;
    logic [P_W-1:0]  yv;
    logic [P_W-1:0]  zv;
    logic [P_W-1:0]  casc;
    logic            ci;
    logic [A_W-1:0]  aSrc;
    logic [B_W-1:0]  bSrc;
    logic [A_W-1:0]  aCasc;
    logic [B_W-1:0]  bCasc;

    always_comb
    begin
        s_d   = s_q;
        xv    = '0;
        yv    = '0;
        zv    = '0;
        casc  = '0;
        ci    = 1'b0;
        aSrc  = '0;
        bSrc  = '0;
        aCasc = '0;
        bCasc = '0;
        for (int i = 0; i < NSLICE; i++)
        begin
            // Slice 1 takes its cascade from slice 0's input registers.
            aCasc = (i == 0) ? lnk.aCascadeIn : s_q.a[0];
            bCasc = (i == 0) ? lnk.bCascadeIn : s_q.b[0];
            aSrc  = lnk.aFromCascade[i] ? aCasc : lnk.aOperand;
            bSrc  = lnk.bFromCascade[i] ? bCasc : lnk.bOperand;
            casc  = (i == 0) ? '0 : s_q.p[0];
            unique case (s_q.xyz[i][1:0])
                XM_ZERO: xv = '0;
                // Both partial products ride on X, so Y adds nothing.
                XM_MULT: xv = prod_ext(s_q.m[i]);
                XM_P:    xv = s_q.p[i];
                XM_AB:   xv = P_W'({s_q.a[i], s_q.b[i]});
            endcase
            unique case (s_q.xyz[i][3:2])
                YM_ZERO: yv = '0;
                YM_MULT: yv = '0;
                YM_ONES: yv = '1;
                YM_C:    yv = s_q.c[i];
            endcase
            zv = z_pick(s_q.xyz[i][6:4], casc, s_q.p[i], s_q.c[i]);
            ci = carry_pick(s_q.csel[i], s_q.p[i][P_W-1],
                            s_q.cin[i]);
            if (lnk.ce)
            begin
                s_d.a[i]    = aSrc;
                s_d.b[i]    = bSrc;
                // Product bits hold K-left and 18-K-right shifts at once.
                s_d.m[i]    = mul_ext(s_q.a[i], s_q.b[i]);
                s_d.c[i]    = lnk.cOperand;
                s_d.xyz[i]  = lnk.xyzMuxSelect[i];
                s_d.alu[i]  = lnk.aluFunctionSelect[i];
                s_d.csel[i] = lnk.carrySourceSelect[i];
                s_d.cin[i]  = lnk.carryIn[i];
                s_d.p[i]    = alu_op(xv, yv, zv, ci, s_q.alu[i]);
            end
            if (lnk.resultClear)
            begin
                s_d.p[i] = '0;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Left result in P[24:0], right in P[42:18] of slice 0.
    assign lnk.result           = s_q.p;
    assign lnk.bCascadeOut      = s_q.b[0];
    assign lnk.resultCascadeOut = s_q.p[NSLICE-1];

endmodule

// >>> test/msh_link_monitor.sv
// Assertions on the link between the fabric end and the slice pair.
`timescale 1ns/1ps
module msh_link_monitor
(
    input wire logic                           clk,
    input wire logic                           rst_n,
    input wire logic                           ce,
    input wire logic                           resultClear,
    input wire logic [msh_pkg::A_W-1:0]        aOperand,
    input wire logic [msh_pkg::B_W-1:0]        bOperand,
    input wire logic [1:0]                     aFromCascade,
    input wire logic [1:0]                     bFromCascade,
    input wire logic [1:0][msh_pkg::XYZ_W-1:0] xyzMuxSelect,
    input wire logic [1:0][msh_pkg::ALU_W-1:0] aluFunctionSelect,
    input wire logic [1:0][msh_pkg::P_W-1:0]   result,
    input wire logic [msh_pkg::B_W-1:0]        bCascadeOut
);
    import msh_pkg::*;
    // Product with the sign correction applied; a negative code is undone.
    logic signed [P_W-1:0] prodFix;
    assign prodFix = bOperand[B_MSB] ?
        -($signed(aOperand) * $signed(bOperand)) :
        $signed(aOperand) * $signed(bOperand);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    property p_sub_first;
        ce |=> aluFunctionSelect[0][1:0] == {2{$past(bOperand[B_MSB])}};
    endproperty
    a_sub_first: assert property (p_sub_first)
        else $error("slice 0 function does not follow the code sign");
    property p_sub_second;
        ce ##1 ce |=>
            aluFunctionSelect[1][1:0] == {2{$past(bOperand[B_MSB], 2)}};
    endproperty
    a_sub_second: assert property (p_sub_second)
        else $error("slice 1 function not delayed with its product");
    property p_b_cascade;
        ce |=> bCascadeOut == $past(bOperand);
    endproperty
    a_b_cascade: assert property (p_b_cascade)
        else $error("B cascade does not carry the sampled code");
    property p_first_result;
        (ce && !resultClear)[*4] |-> $signed(result[0]) == $past(prodFix, 3);
    endproperty
    a_first_result: assert property (p_first_result)
        else $error("slice 0 result wrong three edges after operands");
    property p_second_result;
        (ce && !resultClear)[*5] |-> $signed(result[1]) ==
            ($signed($past(result[0])) >>> CASC_SHIFT) + $past(prodFix, 4);
    endproperty
    a_second_result: assert property (p_second_result)
        else $error("slice 1 sum of product and cascade wrong");
    property p_clear;
        resultClear |=> result[0] == '0 && result[1] == '0;
    endproperty
    a_clear: assert property (p_clear)
        else $error("result not cleared");
    property p_static_ctl;
        xyzMuxSelect[0] == XYZ_MULT && xyzMuxSelect[1] == XYZ_MULT_CASC &&
            aFromCascade == 2'h2 && bFromCascade == 2'h2;
    endproperty
    a_static_ctl: assert property (p_static_ctl)
        else $error("operand source or mux select wrong");
    property p_run;
        rst_n[*3] |-> ce && !resultClear;
    endproperty
    a_run: assert property (p_run)
        else $error("clock enable not held after reset");
    property p_onehot;
        $onehot0(bOperand);
    endproperty
    a_onehot: assert property (p_onehot)
        else $error("shift code is not one-hot");
endmodule

// >>> test/multiplier_based_shifter_test.sv
// Self-checking bench for the fabric end joined to the slice pair.
`timescale 1ns/1ps
module multiplier_based_shifter_test;
    import msh_pkg::*;
    logic             clk = 1'b0;
    logic             rst_n = 1'b0;
    logic             inValid = 1'b0;
    logic [A_W-1:0]   inData = '0;
    logic [K_W-1:0]   inShift = '0;
    msh_mode_type     inMode = SH_ARITH;
    logic             outValid;
    logic [A_W-1:0]   outLeft;
    logic [A_W-1:0]   outRight;
    logic [ROT_W-1:0] outRotate;
    logic [ROT_W:0]   rot;
    int               errors = 0;
    int               compares = 0;
    int               cyc = 0;
    int               qCyc[$];
    logic [A_W-1:0]   qLeft[$];
    logic [A_W-1:0]   qRight[$];
    logic [ROT_W:0]   qRot[$];
    msh_link_if lnk ();
    msh_fabric_ctl msh_fabric_ctl_i
    (
        .clk(clk), .rst_n(rst_n), .inValid(inValid), .inData(inData),
        .inShift(inShift), .inMode(inMode), .outValid(outValid),
        .outLeft(outLeft), .outRight(outRight), .outRotate(outRotate),
        .lnk(lnk)
    );
    msh_slice_pair msh_slice_pair_i (.clk(clk), .rst_n(rst_n), .lnk(lnk));
    msh_link_monitor msh_link_monitor_i
    (
        .clk(clk), .rst_n(rst_n), .ce(lnk.ce),
        .resultClear(lnk.resultClear), .aOperand(lnk.aOperand),
        .bOperand(lnk.bOperand), .aFromCascade(lnk.aFromCascade),
        .bFromCascade(lnk.bFromCascade), .xyzMuxSelect(lnk.xyzMuxSelect),
        .aluFunctionSelect(lnk.aluFunctionSelect), .result(lnk.result),
        .bCascadeOut(lnk.bCascadeOut)
    );
    ////////////////////////////////////////////////////////////////////////
    always #12.5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    task automatic check(input logic [P_W-1:0] seen,
                         input logic [P_W-1:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Queues one beat; the answer is due five edges after it is taken.
    task automatic beat(input logic [A_W-1:0] d, input logic [K_W-1:0] s,
                        input msh_mode_type m);
        logic [K_W-1:0]        k;
        logic [A_W-1:0]        a;
        logic signed [P_W-1:0] p;
        logic [2*ROT_W-1:0]    w;
        @(posedge clk);
        inValid <= 1'b1;
        inData <= d;
        inShift <= s;
        inMode <= m;
        k = (s > K_MAX) ? K_MAX : s;
        for (int i = 0; i < A_W; i++)
            a[i] = (m == SH_REVERSE) ? d[A_W-1-i] : d[i];
        p = $signed(a);
        p = p <<< k;
        w = {d[ROT_W-1:0], d[ROT_W-1:0]} << k;
        qCyc.push_back(cyc + 7);
        qLeft.push_back(p[A_W-1:0]);
        qRight.push_back((m == SH_REVERSE) ? d >> k : p[42:18]);
        qRot.push_back({m == SH_ROTATE, w[2*ROT_W-1:ROT_W]});
    endtask
    task automatic idle();
        @(posedge clk);
        inValid <= 1'b0;
    endtask
    task automatic drain();
        for (int i = 0; i < 20 && qCyc.size() > 0; i++)
            @(negedge clk);
        check(qCyc.size(), 0);
    endtask
    task automatic sweep(input logic [A_W-1:0] d, input msh_mode_type m0,
                         input msh_mode_type m1);
        for (int k = 0; k <= 17; k++)
            beat(d, k[K_W-1:0], k[0] ? m1 : m0);
        idle();
        drain();
    endtask
    always @(negedge clk)
    begin
        if (rst_n === 1'b1 && outValid !== 1'b0)
        begin
            if (qCyc.size() == 0)
                check(outValid, 1'b0);
            else
            begin
                check(cyc, qCyc.pop_front());
                check(outLeft, qLeft.pop_front());
                check(outRight, qRight.pop_front());
                rot = qRot.pop_front();
                if (rot[ROT_W])
                    check(outRotate, rot[ROT_W-1:0]);
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        @(negedge clk);
        check(outValid, 1'b0);
        check(lnk.result[0], '0);
        beat(25'h0033333, 5'h03, SH_LOGIC);
        idle();
        repeat (3) @(posedge clk);
        rst_n <= 1'b0;
        @(negedge clk);
        check(lnk.result[0], 48'h000000199998);
        @(negedge clk);
        check(lnk.result[0], '0);
        check(lnk.result[1], '0);
        check(outValid, 1'b0);
        @(posedge clk);
        rst_n <= 1'b1;
        qCyc.delete();
        qLeft.delete();
        qRight.delete();
        qRot.delete();
    endtask
    task automatic t_arith();
        sweep(25'h1FF3333, SH_ARITH, SH_ARITH);
        sweep(25'h0015555, SH_ARITH, SH_ARITH);
    endtask
    // Modes alternate beat by beat so the controls change every cycle.
    task automatic t_logic_rotate();
        sweep(25'h0033333, SH_LOGIC, SH_ROTATE);
        sweep(25'h0020001, SH_ROTATE, SH_LOGIC);
    endtask
    task automatic t_reverse();
        sweep(25'h0B33333, SH_REVERSE, SH_REVERSE);
        sweep(25'h1FF3333, SH_REVERSE, SH_ARITH);
        beat(25'h1ABCDEF, 5'h1F, SH_REVERSE);
        beat(25'h1ABCDEF, 5'h12, SH_REVERSE);
        idle();
        drain();
    endtask
    // About 170 cycles of traffic; a far longer span means a hang.
    initial
    begin
        #(25 * 3000);
        errors++;
        finish_test();
    end
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_arith();
        t_logic_rotate();
        t_reverse();
        finish_test();
    end
endmodule
